// file: pkg/homing_cfg.svh
// Homing sequencer constants: register offsets, field positions, reset values, timing counts.
// Assumes a 100 MHz REF_CLK and an APB bus with 32-bit data.
`ifndef HOMING_CFG_SVH
`define HOMING_CFG_SVH
`define OFF_CTRL        12'h000
`define OFF_SPEED       12'h004
`define OFF_STOP_CUR    12'h008
`define OFF_STOP_TIME   12'h00C
`define OFF_TIMEOUT     12'h010
`define OFF_OFFSET      12'h014
`define OFF_STATUS      12'h018
`define OFF_POS         12'h01C
`define OFF_HOME        12'h020
`define OFF_IRQ_STAT    12'h024
`define OFF_IRQ_EN      12'h028
`define OFF_IRQ_CLR     12'h02C
`define CTRL_START_BIT  0
`define CTRL_DIR_BIT    1
`define CTRL_LEFT_LSB   2
`define CTRL_RIGHT_LSB  4
`define CTRL_INDEX_BIT  6
`define CTRL_RESET      32'h0000_0000
`define SPEED_RESET     16'h0001
`define STOP_CUR_RESET  16'h0100
`define STOP_TIME_RESET 32'h0000_0064
`define TIMEOUT_RESET   32'h05F5_E100
`define IRQ_DONE_BIT    0
`define IRQ_FAIL_BIT    1
`define IRQ_BOUND_BIT   2
`define IRQ_WIDTH       3
`endif

// file: pkg/homing_pkg.sv
// Homing sequencer types: side conditions, first direction and sequence states.
// No assumptions beyond a SystemVerilog compiler.
`default_nettype none
package homing_pkg;
  typedef enum logic [1:0] {
    COND_NONE    = 2'b00,
    COND_ENDSTOP = 2'b01,
    COND_SWITCH  = 2'b10
  } side_cond_e;

  typedef enum logic {
    FIRST_LEFT  = 1'b0,
    FIRST_RIGHT = 1'b1
  } first_dir_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FIRST  = 3'b001,
    ST_SECOND = 3'b010,
    ST_INDEX  = 3'b011,
    ST_MOVE   = 3'b100,
    ST_DONE   = 3'b101,
    ST_FAIL   = 3'b110
  } home_state_e;
endpackage
`default_nettype wire

// file: rtl/homing_seq.sv
// Two-sided homing sequencer with APB register access.
// Assumes a motor position loop outside that follows the speed command,
// a current measurement on REF_CLK, and pins for switches and encoder index.
//
// Functional notes
// RQ1 - Find left and right boundary, home is their midpoint, stop there.
// RQ2 - Search runs at the low homing speed, starting in selected direction.
// RQ3 - First direction is left or right and picks the side searched first.
// RQ4 - Travel toward first side until met, then reverse to other side.
// RQ5 - Left condition: not used, end stop, or left limit switch.
// RQ6 - Right condition: not used, end stop, or right limit switch.
// RQ7 - End stop found when current exceeds threshold for configured time.
// RQ8 - With index search enabled, home is the index seen during search.
// RQ9 - After left boundary with index search, move right, first index is home; code keeps the last index seen moving right.
// RQ10 - Among several indexes, choose the one nearest the right-side boundary.
// RQ11 - First direction at unused side while other side used means failure.
// RQ12 - Configurer keeps speed times stop time below maximum position error.
// RQ13 - Timeout aborts with failure; report success, show busy while running.
// RQ14 - Home offset shifts home right if positive, left if negative.
// RQ15 - Start while a sequence runs is ignored until it ends.
`timescale 1ns/100ps
`default_nettype none
`include "homing_cfg.svh"
module homing_seq (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        LEFT_SWITCH,
  input  wire logic        RIGHT_SWITCH,
  input  wire logic        ENC_INDEX,
  input  wire logic [15:0] MOTOR_CURRENT,
  input  wire logic [31:0] MOTOR_POSITION,
  output var  logic signed [15:0] SPEED_CMD,
  output var  logic        HOME_BUSY,
  output var  logic        HOME_OK,
  output var  logic        HOME_FAIL,
  output var  logic        IRQ
);
  // Configuration registers
  logic        dir_reg;
  logic [1:0]  left_cond_reg;
  logic [1:0]  right_cond_reg;
  logic        index_en_reg;
  logic [15:0] speed_reg;
  logic [15:0] stop_cur_reg;
  logic [31:0] stop_time_reg;
  logic [31:0] timeout_reg;
  logic [31:0] offset_reg;
  logic [`IRQ_WIDTH-1:0] irq_stat_reg;
  logic [`IRQ_WIDTH-1:0] irq_en_reg;

  // Sequencer state
  homing_pkg::home_state_e state_reg;
  homing_pkg::home_state_e state_next;
  logic        going_left_reg;
  logic [31:0] bound_a_reg;
  logic [31:0] target_reg;
  logic [31:0] home_reg;
  logic [31:0] stop_cnt_reg;
  logic [31:0] tmo_cnt_reg;
  logic        index_seen_reg;
  logic [31:0] index_pos_reg;
  logic        index_prev_reg;
  logic [31:0] rdata_reg;

  // Synchronised pins
  logic left_sw;
  logic right_sw;
  logic index_s;

  input_sync u_sync_left (
    .REF_CLK (REF_CLK),
    .RST     (RST),
    .din     (LEFT_SWITCH),
    .dout    (left_sw)
  );
  input_sync u_sync_right (
    .REF_CLK (REF_CLK),
    .RST     (RST),
    .din     (RIGHT_SWITCH),
    .dout    (right_sw)
  );
  input_sync u_sync_index (
    .REF_CLK (REF_CLK),
    .RST     (RST),
    .din     (ENC_INDEX),
    .dout    (index_s)
  );

  // APB decode
  wire apb_wr    = PSEL & PENABLE & PWRITE;
  wire apb_rd    = PSEL & PENABLE & ~PWRITE;
  wire wr_ctrl   = apb_wr && (PADDR == `OFF_CTRL);
  wire wr_irqclr = apb_wr && (PADDR == `OFF_IRQ_CLR);
  wire addr_ok   = (PADDR[1:0] == 2'b00) && (PADDR <= `OFF_IRQ_CLR);

  wire busy = (state_reg != homing_pkg::ST_IDLE) && (state_reg != homing_pkg::ST_DONE) &&
              (state_reg != homing_pkg::ST_FAIL);
  wire start = wr_ctrl && PWDATA[`CTRL_START_BIT] && !busy; // RQ15

  // Side selection for the current leg
  wire [1:0] cur_cond = going_left_reg ? left_cond_reg : right_cond_reg; // RQ5 RQ6
  wire       cur_sw   = going_left_reg ? left_sw : right_sw;
  wire       over_cur = MOTOR_CURRENT > stop_cur_reg;
  wire       stop_hit = (stop_cnt_reg >= stop_time_reg) && (stop_time_reg != 32'h0000_0000); // RQ7
  wire       bound_met =
    ((cur_cond == homing_pkg::COND_SWITCH) && cur_sw) ||
    ((cur_cond == homing_pkg::COND_ENDSTOP) && stop_hit) ||
    (cur_cond == homing_pkg::COND_NONE);
  wire [1:0] first_cond = dir_reg ? right_cond_reg : left_cond_reg;
  wire [1:0] other_cond = dir_reg ? left_cond_reg : right_cond_reg;
  wire       bad_setup  = (first_cond == homing_pkg::COND_NONE) &&
                          (other_cond != homing_pkg::COND_NONE); // RQ11
  wire       index_rise = index_s & ~index_prev_reg;
  wire       timed_out  = busy && (tmo_cnt_reg >= timeout_reg);
  wire [32:0] mid_sum   = {bound_a_reg[31], bound_a_reg} + {MOTOR_POSITION[31], MOTOR_POSITION};
  wire [31:0] midpoint  = mid_sum[32:1]; // RQ1
  wire [31:0] home_base = index_seen_reg ? index_pos_reg : midpoint; // RQ8
  wire [31:0] home_sh   = home_base + offset_reg; // RQ14
  // Position follows the speed command one clock late, so the stop is judged one step ahead
  wire [31:0] pos_ahead = MOTOR_POSITION + {{16{SPEED_CMD[15]}}, SPEED_CMD};
  wire [31:0] goal      = (state_reg == homing_pkg::ST_SECOND) ? home_sh : target_reg;
  wire        at_target = (pos_ahead == goal);
  wire        tgt_right = $signed(goal) > $signed(pos_ahead);
  wire        left_next = start ? (dir_reg == homing_pkg::FIRST_LEFT) :
                          (state_reg == homing_pkg::ST_FIRST && bound_met) ? ~going_left_reg : going_left_reg;

  // State transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      homing_pkg::ST_IDLE, homing_pkg::ST_DONE, homing_pkg::ST_FAIL: begin
        if (start) begin
          state_next = bad_setup ? homing_pkg::ST_FAIL : homing_pkg::ST_FIRST;
        end
      end
      homing_pkg::ST_FIRST: begin
        if (bound_met) begin
          state_next = homing_pkg::ST_SECOND; // RQ4
        end
      end
      homing_pkg::ST_SECOND: begin
        if (bound_met) begin
          state_next = homing_pkg::ST_MOVE;
        end
      end
      homing_pkg::ST_INDEX: begin
        state_next = homing_pkg::ST_MOVE;
      end
      homing_pkg::ST_MOVE: begin
        if (at_target) begin
          state_next = homing_pkg::ST_DONE; // RQ13
        end
      end
      default: begin
        state_next = homing_pkg::ST_IDLE;
      end
    endcase
    if (timed_out) begin
      state_next = homing_pkg::ST_FAIL; // RQ13
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= homing_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Leg direction, boundaries and target
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      going_left_reg <= 1'b1;
      bound_a_reg    <= 32'h0000_0000;
      target_reg     <= 32'h0000_0000;
      home_reg       <= 32'h0000_0000;
    end else if (start) begin
      going_left_reg <= (dir_reg == homing_pkg::FIRST_LEFT); // RQ3
    end else if (state_reg == homing_pkg::ST_FIRST && bound_met) begin
      going_left_reg <= ~going_left_reg; // RQ4
      bound_a_reg    <= MOTOR_POSITION;
    end else if (state_reg == homing_pkg::ST_SECOND && bound_met) begin
      target_reg     <= home_sh; // RQ1 RQ14
      home_reg       <= home_sh;
    end
  end

  // End-stop dwell counter: resets whenever current drops or a leg changes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      stop_cnt_reg <= 32'h0000_0000;
    end else if (!busy || !over_cur || (state_next != state_reg)) begin
      stop_cnt_reg <= 32'h0000_0000;
    end else if (stop_cnt_reg != 32'hFFFF_FFFF) begin
      stop_cnt_reg <= stop_cnt_reg + 32'h0000_0001; // RQ7
    end
  end

  // Timeout counter
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tmo_cnt_reg <= 32'h0000_0000;
    end else if (!busy) begin
      tmo_cnt_reg <= 32'h0000_0000;
    end else begin
      tmo_cnt_reg <= tmo_cnt_reg + 32'h0000_0001; // RQ13
    end
  end

  // Index capture during the search. Moving right, the latest index is kept so the one
  // nearest the right boundary wins; moving left, only the first one is kept.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      index_prev_reg <= 1'b0;
      index_seen_reg <= 1'b0;
      index_pos_reg  <= 32'h0000_0000;
    end else begin
      index_prev_reg <= index_s;
      if (start) begin
        index_seen_reg <= 1'b0;
      end else if (index_en_reg && index_rise &&
                   (state_reg == homing_pkg::ST_FIRST || state_reg == homing_pkg::ST_SECOND)) begin
        if (!going_left_reg) begin
          index_seen_reg <= 1'b1; // RQ9 RQ10
          index_pos_reg  <= MOTOR_POSITION;
        end else if (!index_seen_reg) begin
          index_seen_reg <= 1'b1; // RQ8
          index_pos_reg  <= MOTOR_POSITION;
        end
      end
    end
  end

  // Speed command: only the low homing speed is ever used
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SPEED_CMD <= 16'h0000;
    end else if (state_next == homing_pkg::ST_FIRST || state_next == homing_pkg::ST_SECOND) begin
      SPEED_CMD <= left_next ? -$signed(speed_reg) : $signed(speed_reg); // RQ2
    end else if (state_next == homing_pkg::ST_MOVE && !at_target) begin
      SPEED_CMD <= tgt_right ? $signed(speed_reg) : -$signed(speed_reg); // RQ14
    end else begin
      SPEED_CMD <= 16'h0000; // RQ1
    end
  end

  // Configuration writes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dir_reg        <= 1'b0;
      left_cond_reg  <= 2'b00;
      right_cond_reg <= 2'b00;
      index_en_reg   <= 1'b0;
      speed_reg      <= `SPEED_RESET;
      stop_cur_reg   <= `STOP_CUR_RESET;
      stop_time_reg  <= `STOP_TIME_RESET;
      timeout_reg    <= `TIMEOUT_RESET;
      offset_reg     <= 32'h0000_0000;
      irq_en_reg     <= {`IRQ_WIDTH{1'b0}};
    end else if (apb_wr && !busy) begin
      // Setup is frozen while a sequence runs so the legs stay consistent
      if (PADDR == `OFF_CTRL) begin
        dir_reg        <= PWDATA[`CTRL_DIR_BIT];
        left_cond_reg  <= PWDATA[`CTRL_LEFT_LSB +: 2];
        right_cond_reg <= PWDATA[`CTRL_RIGHT_LSB +: 2];
        index_en_reg   <= PWDATA[`CTRL_INDEX_BIT];
      end else if (PADDR == `OFF_SPEED) begin
        speed_reg <= PWDATA[15:0];
      end else if (PADDR == `OFF_STOP_CUR) begin
        stop_cur_reg <= PWDATA[15:0];
      end else if (PADDR == `OFF_STOP_TIME) begin
        stop_time_reg <= PWDATA;
      end else if (PADDR == `OFF_TIMEOUT) begin
        timeout_reg <= PWDATA;
      end else if (PADDR == `OFF_OFFSET) begin
        offset_reg <= PWDATA;
      end else if (PADDR == `OFF_IRQ_EN) begin
        irq_en_reg <= PWDATA[`IRQ_WIDTH-1:0];
      end
    end else if (apb_wr && PADDR == `OFF_IRQ_EN) begin
      irq_en_reg <= PWDATA[`IRQ_WIDTH-1:0];
    end
  end

  // Sticky events; a set in the same cycle as a clear wins
  wire [`IRQ_WIDTH-1:0] ev_set = {
    (state_reg == homing_pkg::ST_FIRST && bound_met),
    (state_next == homing_pkg::ST_FAIL && state_reg != homing_pkg::ST_FAIL),
    (state_next == homing_pkg::ST_DONE && state_reg != homing_pkg::ST_DONE)};
  wire [`IRQ_WIDTH-1:0] ev_clr = wr_irqclr ? PWDATA[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_stat_reg <= {`IRQ_WIDTH{1'b0}};
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~ev_clr) | ev_set;
    end
  end

  // Read mux
  wire [31:0] status_word = {29'h0, HOME_FAIL, HOME_OK, HOME_BUSY};
  wire [31:0] ctrl_word   = {25'h0, index_en_reg, right_cond_reg, left_cond_reg, dir_reg, busy};
  wire [31:0] rd_mux =
    (PADDR == `OFF_CTRL)      ? ctrl_word :
    (PADDR == `OFF_SPEED)     ? {16'h0000, speed_reg} :
    (PADDR == `OFF_STOP_CUR)  ? {16'h0000, stop_cur_reg} :
    (PADDR == `OFF_STOP_TIME) ? stop_time_reg :
    (PADDR == `OFF_TIMEOUT)   ? timeout_reg :
    (PADDR == `OFF_OFFSET)    ? offset_reg :
    (PADDR == `OFF_STATUS)    ? status_word :
    (PADDR == `OFF_POS)       ? MOTOR_POSITION :
    (PADDR == `OFF_HOME)      ? home_reg :
    (PADDR == `OFF_IRQ_STAT)  ? {29'h0, irq_stat_reg} :
    (PADDR == `OFF_IRQ_EN)    ? {29'h0, irq_en_reg} :
    32'h0000_0000;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      rdata_reg <= rd_mux;
    end
  end

  assign PRDATA    = rdata_reg;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL & PENABLE & ~addr_ok;
  assign HOME_BUSY = busy; // RQ13
  assign HOME_OK   = (state_reg == homing_pkg::ST_DONE);
  assign HOME_FAIL = (state_reg == homing_pkg::ST_FAIL); // RQ11
  assign IRQ       = |(irq_stat_reg & irq_en_reg);
endmodule
`default_nettype wire

// file: rtl/input_sync.sv
// Three-stage synchroniser for pin inputs; output changes when stages two and three agree.
// Assumes the input is asynchronous to REF_CLK.
`timescale 1ns/100ps
`default_nettype none
module input_sync (
  input  wire logic REF_CLK,
  input  wire logic RST,
  input  wire logic din,
  output var  logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;
  wire  agree = (s2_reg == s3_reg);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        out_reg <= s3_reg;
      end
    end
  end

  assign dout = out_reg;
endmodule
`default_nettype wire

// file: verification/homing_seq_props.sv
// Checker for the homing sequencer, watching only its top ports.
// Assumes one clock domain and APB accesses of one access cycle.
`timescale 1ns/100ps
`default_nettype none
`include "homing_cfg.svh"
module homing_seq_props (
  input wire logic               REF_CLK,
  input wire logic               RST,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire logic [11:0]        PADDR,
  input wire logic [31:0]        PWDATA,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire logic               LEFT_SWITCH,
  input wire logic               RIGHT_SWITCH,
  input wire logic               ENC_INDEX,
  input wire logic [15:0]        MOTOR_CURRENT,
  input wire logic [31:0]        MOTOR_POSITION,
  input wire logic signed [15:0] SPEED_CMD,
  input wire logic               HOME_BUSY,
  input wire logic               HOME_OK,
  input wire logic               HOME_FAIL,
  input wire logic               IRQ
);
  default clocking dc @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Shadow copies stay valid because config writes other than the interrupt enable are dropped while busy
  logic [31:0] ctrl_reg, speed_reg, tmo_reg, ien_reg, busy_cnt;
  wire logic wr = PSEL && PENABLE && PWRITE;
  wire logic wr_idle = wr && !HOME_BUSY;
  wire logic start = wr_idle && PADDR == `OFF_CTRL && PWDATA[0];
  wire logic l_none = ctrl_reg[3:2] == 2'h0;
  wire logic r_none = ctrl_reg[5:4] == 2'h0;
  wire logic bad = ctrl_reg[1] ? (r_none && !l_none) : (l_none && !r_none);
  wire logic first_used = ctrl_reg[1] ? !r_none : !l_none;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= `CTRL_RESET;
      speed_reg <= {16'h0000, `SPEED_RESET};
      tmo_reg <= `TIMEOUT_RESET;
      ien_reg <= 32'h0000_0000;
      busy_cnt <= 32'h0000_0000;
    end else begin
      if (wr_idle && PADDR == `OFF_CTRL) ctrl_reg <= PWDATA;
      if (wr_idle && PADDR == `OFF_SPEED) speed_reg <= PWDATA;
      if (wr_idle && PADDR == `OFF_TIMEOUT) tmo_reg <= PWDATA;
      if (wr && PADDR == `OFF_IRQ_EN) ien_reg <= PWDATA;
      busy_cnt <= HOME_BUSY ? busy_cnt + 32'h1 : 32'h0;
    end
  end
  a_bad_setup_fails: assert property (start && bad |-> ##[1:2] HOME_FAIL && !HOME_BUSY)
    else $error("unreasonable setup did not fail");
  a_first_leg_dir: assert property (start && !bad && first_used |-> ##1
    (ctrl_reg[1] ? SPEED_CMD > 16'sh0000 : SPEED_CMD < 16'sh0000))
    else $error("first leg in wrong direction");
  a_search_speed: assert property (HOME_BUSY && SPEED_CMD != 16'sh0000 |->
    SPEED_CMD == speed_reg[15:0] || -SPEED_CMD == speed_reg[15:0])
    else $error("speed differs from low homing speed");
  a_stopped_idle: assert property (!HOME_BUSY ##1 !HOME_BUSY |-> SPEED_CMD == 16'sh0000)
    else $error("motor moves while not homing");
  a_end_reported: assert property ($fell(HOME_BUSY) |-> HOME_OK || HOME_FAIL)
    else $error("run ended without result");
  a_ok_exclusive: assert property (HOME_OK |-> !HOME_BUSY && !HOME_FAIL)
    else $error("success shown with busy or failure");
  a_timeout_bound: assert property (busy_cnt <= tmo_reg + 32'h2)
    else $error("run outlived its timeout");
  a_done_irq: assert property ($rose(HOME_OK) && ien_reg[0] |-> ##[0:2] IRQ)
    else $error("enabled done event gave no interrupt");
  a_irq_masked: assert property ((ien_reg[2:0] == 3'h0) [*2] |-> !IRQ)
    else $error("interrupt while all sources masked");
  cover property ($rose(HOME_OK));
  cover property (start && bad);
  cover property ($fell(HOME_BUSY) && HOME_FAIL);
endmodule
bind homing_seq homing_seq_props chk (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .LEFT_SWITCH(LEFT_SWITCH), .RIGHT_SWITCH(RIGHT_SWITCH), .ENC_INDEX(ENC_INDEX),
  .MOTOR_CURRENT(MOTOR_CURRENT), .MOTOR_POSITION(MOTOR_POSITION), .SPEED_CMD(SPEED_CMD),
  .HOME_BUSY(HOME_BUSY), .HOME_OK(HOME_OK), .HOME_FAIL(HOME_FAIL), .IRQ(IRQ));
`default_nettype wire

// file: verification/motor_model.sv
// Behavioural axis: two hard walls, limit switches and two index marks.
// Assumes the speed command is counts per clock.
`timescale 1ns/100ps
`default_nettype none
module motor_model #(
  parameter int WALL_L = -100,
  parameter int WALL_R = 120,
  parameter int SW_AT  = 80,
  parameter int IDX_A  = 30,
  parameter int IDX_B  = 60
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic signed [15:0] speed_cmd,
  output wire logic               left_sw,
  output wire logic               right_sw,
  output wire logic               idx,
  output wire logic [15:0]        current,
  output wire logic [31:0]        position
);
  int pos = 0;
  int nxt;
  // Walls are asymmetric so switch and end stop midpoints differ
  wire logic push = (pos <= WALL_L && speed_cmd < 0) || (pos >= WALL_R && speed_cmd > 0);
  always @(posedge clk or posedge rst) begin
    if (rst) pos <= 0;
    else pos <= nxt;
  end
  always_comb begin
    nxt = pos + int'(speed_cmd);
    if (nxt < WALL_L) nxt = WALL_L;
    if (nxt > WALL_R) nxt = WALL_R;
  end
  assign left_sw = pos <= -SW_AT;
  assign right_sw = pos >= SW_AT;
  // Each mark spans four counts so the pin stays up long enough to pass the input filter
  assign idx = (pos >= IDX_A && pos < IDX_A + 4) || (pos >= IDX_B && pos < IDX_B + 4);
  assign current = push ? 16'h0400 : 16'h0040;
  assign position = pos;
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench: register table over APB, then homing runs on the motor model.
// Assumes the design, checker and motor model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "homing_cfg.svh"
module testbench;
  logic REF_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, MOTOR_POSITION, q;
  logic PREADY, PSLVERR, LEFT_SWITCH, RIGHT_SWITCH, ENC_INDEX, HOME_BUSY, HOME_OK, HOME_FAIL, IRQ, e;
  logic [15:0] MOTOR_CURRENT;
  logic signed [15:0] SPEED_CMD;
  int n_fail = 0, n_tests = 0, cyc;
  typedef struct {logic [11:0] a; logic [31:0] v; logic e;} row_s;
  row_s rows [8] = '{'{`OFF_CTRL, `CTRL_RESET, 1'b0}, '{`OFF_SPEED, {16'h0000, `SPEED_RESET}, 1'b0},
    '{`OFF_STOP_CUR, {16'h0000, `STOP_CUR_RESET}, 1'b0}, '{`OFF_STOP_TIME, `STOP_TIME_RESET, 1'b0},
    '{`OFF_TIMEOUT, `TIMEOUT_RESET, 1'b0}, '{`OFF_STATUS, 32'h0, 1'b0}, '{`OFF_IRQ_STAT, 32'h0, 1'b0},
    '{12'h030, 32'h0, 1'b1}};
  logic [31:0] bad [2] = '{32'h0000_0020, 32'h0000_0006};
  always #5 REF_CLK = ~REF_CLK;
  homing_seq dut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LEFT_SWITCH(LEFT_SWITCH), .RIGHT_SWITCH(RIGHT_SWITCH), .ENC_INDEX(ENC_INDEX),
    .MOTOR_CURRENT(MOTOR_CURRENT), .MOTOR_POSITION(MOTOR_POSITION), .SPEED_CMD(SPEED_CMD),
    .HOME_BUSY(HOME_BUSY), .HOME_OK(HOME_OK), .HOME_FAIL(HOME_FAIL), .IRQ(IRQ));
  motor_model mdl (.clk(REF_CLK), .rst(RST), .speed_cmd(SPEED_CMD), .left_sw(LEFT_SWITCH),
    .right_sw(RIGHT_SWITCH), .idx(ENC_INDEX), .current(MOTOR_CURRENT), .position(MOTOR_POSITION));
  task automatic report_and_stop;
    $display("Checks: %0d, mismatches: %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic settle;
    @(posedge REF_CLK);
    #1;
  endtask
  task automatic go(input logic [31:0] cfg, input logic [31:0] off);
    apb(1'b1, `OFF_OFFSET, off);
    apb(1'b1, `OFF_CTRL, cfg);
    apb(1'b1, `OFF_CTRL, cfg | 32'h0000_0001);
    cyc = 0;
  endtask
  task automatic wait_end;
    settle;
    while (HOME_OK !== 1'b1 && HOME_FAIL !== 1'b1 && cyc < 4000) begin
      settle;
      cyc++;
    end
    chk(cyc < 4000, "homing never ended");
  endtask
  initial begin
    repeat (20000) @(posedge REF_CLK);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge REF_CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(q === rows[i].v && e === rows[i].e, "register reset value");
    end
    $display("Test reset values done");
    apb(1'b1, `OFF_STOP_TIME, 32'h0000_000A);
    apb(1'b1, `OFF_TIMEOUT, 32'h0000_07D0);
    apb(1'b1, `OFF_IRQ_EN, 32'h0000_0001);
    go(32'h0000_0028, 32'hFFFF_FFFB);
    repeat (20) settle;
    chk(SPEED_CMD === 16'hFFFF, "first leg not leftward at low speed");
    apb(1'b1, `OFF_CTRL, 32'h0000_0023);
    settle;
    chk(HOME_BUSY === 1'b1 && SPEED_CMD === 16'hFFFF, "restart disturbed run");
    wait_end;
    chk(HOME_OK === 1'b1 && IRQ === 1'b1, "switch homing not reported");
    chk($signed(MOTOR_POSITION) >= -7 && $signed(MOTOR_POSITION) <= -3, "switch home");
    apb(1'b1, `OFF_IRQ_CLR, 32'h0000_0007);
    settle;
    chk(IRQ === 1'b0, "interrupt not cleared");
    $display("Test switch homing done");
    apb(1'b1, `OFF_IRQ_EN, 32'h0000_0000);
    go(32'h0000_0016, 32'h0000_0007);
    wait_end;
    chk(HOME_OK === 1'b1 && MOTOR_POSITION === 32'h0000_0011, "end stop home");
    apb(1'b0, `OFF_HOME, 32'h0);
    chk(q === 32'h0000_0011, "home register wrong");
    apb(1'b0, `OFF_IRQ_STAT, 32'h0);
    chk(IRQ === 1'b0 && q[0] === 1'b1, "masked done event");
    apb(1'b1, `OFF_IRQ_CLR, 32'h0000_0007);
    $display("Test end stop homing done");
    go(32'h0000_0068, 32'h0);
    wait_end;
    chk(HOME_OK === 1'b1 && $signed(MOTOR_POSITION) >= 60 && $signed(MOTOR_POSITION) <= 66, "index");
    $display("Test index homing done");
    foreach (bad[i]) begin
      go(bad[i], 32'h0);
      repeat (3) settle;
      chk(HOME_FAIL === 1'b1 && SPEED_CMD === 16'h0000, "unreasonable setup accepted");
    end
    $display("Test bad setups done");
    apb(1'b1, `OFF_IRQ_CLR, 32'h0000_0007);
    apb(1'b1, `OFF_TIMEOUT, 32'h0000_0032);
    go(32'h0000_0016, 32'h0);
    wait_end;
    chk(HOME_FAIL === 1'b1 && cyc >= 45 && cyc <= 55, "timeout not enforced");
    apb(1'b0, `OFF_IRQ_STAT, 32'h0);
    chk(q[1] === 1'b1, "fail event not recorded");
    $display("Test timeout done");
    report_and_stop;
  end
endmodule
`default_nettype wire
